// File: rtl/bfsk_ctrl.v
// BFSK burst frequency and bit-stream controller, APB slave.
// Assumes MAC-side inputs synchronous to clock; synthesizer and PA
// follow toneFreq and paOn directly.
// How it works
// - Bit one sends carrier plus deviation, zero sends carrier minus it.
// - Mode 0 only: 500 bps downlink and A'', 62.5 bps A uplink.
// - A downlink carrier sits on grid slot 10 or 40, chosen by config.
// - A'' links in both directions always use grid slot 25.
// - Channel centres step 15 kHz in uplink, 25 kHz in downlink.
// - Hopping uses a table of downlink channels in planned order.
// - Hop position loads at slot 0, then advances per slot modulo length.
// - Frame-start load value is the low HOP_AW bits of the configured hop start offset.
// - Hop start offset is offered out for the sync PDU.
// - Only A uplink uses the random carrier pick; others plain BFSK.
// - Base station keeps phase continuous; end point may choose.
// - New uplink carrier each burst, except second half of a pair.
// - Uplink carrier is centre minus half span plus step times grain.
// - A 16 ms guard at reduced power precedes each burst.
// - Power ramps settle within 500 us of burst start and end.
// - Carrier retunes only while power is at the guard level.
// - Guard bits alternate at the bit rate, starting with one.
// - A timeslot is 0.4 s and paces the hop position.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "bfsk_regs.vh"
module bfsk_ctrl #(
    parameter HOP_DEPTH = 16,
    parameter HOP_AW = 4,
    parameter STEP_HZ = 500,
    parameter BIT_DL_CYC = `BFSK_BIT_DL_CYC,
    parameter BIT_UL_CYC = `BFSK_BIT_UL_CYC,
    parameter GUARD_CYC = `BFSK_GUARD_CYC,
    parameter RAMP_CYC = `BFSK_RAMP_CYC,
    parameter SLOT_CYC = `BFSK_SLOT_CYC
) (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire frameStart,
    input wire burstReq,
    input wire [15:0] burstBits,
    input wire [7:0] macStep,
    input wire pairSecond,
    input wire macBit,
    output reg bitTake,
    output reg txBit,
    output reg [31:0] toneFreq,
    output reg synthLoad,
    output reg paOn,
    output reg rampBusy,
    output reg guardActive,
    output reg burstDone,
    output reg [7:0] hopOffset,
    output reg phaseCont
);
    // One-hot sequencer states; the status register shows them raw
    localparam S_IDLE = 4'h1;
    localparam S_GUARD = 4'h2;
    localparam S_BURST = 4'h4;
    localparam S_DOWN = 4'h8;

    // Configuration copies; only the defined fields are kept
    reg [31:0] ctrl_ff;
    reg [7:0] chan_ff;
    reg [31:0] dlBase_ff;
    reg [31:0] ulBase_ff;
    reg [7:0] hopLen_ff;
    reg [7:0] hopTab_ff [0:HOP_DEPTH-1];
    reg [HOP_AW-1:0] hopIdx_ff;
    reg [7:0] slotNum_ff;
    reg [31:0] slotCnt_ff;
    reg [3:0] state_ff;
    reg [31:0] tmr_ff;
    reg [31:0] bitCnt_ff;
    reg [15:0] bitsLeft_ff;
    reg [7:0] step_ff;
    reg [31:0] carrier_ff;

    // Writes commit on the access edge only; a refused address never lands
    wire wrEn = psel & penable & pwrite & pready;
    wire [1:0] link = ctrl_ff[`BFSK_F_LINK_HI:`BFSK_F_LINK_LO];
    wire modeOk = ctrl_ff[`BFSK_F_MODE_HI:`BFSK_F_MODE_LO] == 4'h0;
    wire isAul = link == `BFSK_LINK_AUL;
    wire [31:0] bitCyc = isAul ? BIT_UL_CYC : BIT_DL_CYC;
    wire lastBitCyc = bitCnt_ff == bitCyc - 32'h1;

    // APB: pready rises for exactly one access cycle per transfer
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                // Unmapped or unaligned: error, reads zero, write dropped
                pslverr <= paddr > `BFSK_STATUS || paddr[1:0] != 2'h0;
                case (paddr)
                    `BFSK_CTRL: prdata <= ctrl_ff;
                    `BFSK_CHAN: prdata <= {24'h000000, chan_ff};
                    `BFSK_DLBASE: prdata <= dlBase_ff;
                    `BFSK_ULBASE: prdata <= ulBase_ff;
                    `BFSK_HOPOFS: prdata <= {24'h000000, hopOffset};
                    `BFSK_HOPLEN: prdata <= {24'h000000, hopLen_ff};
                    `BFSK_STATUS: prdata <= {12'h000, state_ff,
                        slotNum_ff, {(8-HOP_AW){1'b0}}, hopIdx_ff};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `BFSK_CTRL_RST;
            chan_ff <= 8'h00;
            dlBase_ff <= 32'h00000000;
            ulBase_ff <= 32'h00000000;
            hopOffset <= 8'h00;
            hopLen_ff <= 8'h01;
            phaseCont <= 1'b0;
        end else begin
            if (wrEn && paddr == `BFSK_CTRL)
                ctrl_ff <= {20'h00000, pwdata[11:8], 1'b0, pwdata[6:0]};
            if (wrEn && paddr == `BFSK_CHAN)
                chan_ff <= pwdata[7:0];
            if (wrEn && paddr == `BFSK_DLBASE)
                dlBase_ff <= pwdata;
            if (wrEn && paddr == `BFSK_ULBASE)
                ulBase_ff <= pwdata;
            if (wrEn && paddr == `BFSK_HOPOFS)
                hopOffset <= pwdata[7:0];
            if (wrEn && paddr == `BFSK_HOPLEN)
                hopLen_ff <= pwdata[7:0];
            // Base station role forces it; an end point may opt in
            phaseCont <= ctrl_ff[`BFSK_F_BASE] | ctrl_ff[`BFSK_F_EPPC];
        end
    end

    // Hop table entries: write pwdata[15:8] selects the entry
    // Small table in flip-flops; too shallow to be worth a memory macro
    genvar g;
    generate
        for (g = 0; g < HOP_DEPTH; g = g + 1) begin : gHop
            always @(posedge clock or posedge rst) begin
                if (rst)
                    hopTab_ff[g] <= 8'h00;
                else if (wrEn && paddr == `BFSK_HOPWR && pwdata[15:8] == g)
                    hopTab_ff[g] <= pwdata[7:0];
            end
        end
    endgenerate

    // Timeslot timer and hop position; frameStart marks slot 0
    // frameStart wins over the slot tick so slot 0 always starts fresh
    wire [7:0] hopNext = {{(8-HOP_AW){1'b0}}, hopIdx_ff} + 8'h01;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            slotCnt_ff <= 32'h00000000;
            slotNum_ff <= 8'h00;
            hopIdx_ff <= {HOP_AW{1'b0}};
        end else if (frameStart) begin
            slotCnt_ff <= 32'h00000000;
            slotNum_ff <= 8'h00;
            hopIdx_ff <= hopOffset[HOP_AW-1:0];
        end else if (slotCnt_ff == SLOT_CYC - 1) begin
            slotCnt_ff <= 32'h00000000;
            slotNum_ff <= slotNum_ff + 8'h01;
            if (hopNext >= hopLen_ff)
                hopIdx_ff <= {HOP_AW{1'b0}};
            else
                hopIdx_ff <= hopNext[HOP_AW-1:0];
        end else begin
            slotCnt_ff <= slotCnt_ff + 32'h1;
        end
    end

    // Carrier for the coming burst
    // Evaluated every cycle but latched only at guard entry, so neither
    // a hop tick nor a register write moves a burst in flight
    reg [7:0] stepSel;
    reg [7:0] chanSel;
    reg [31:0] dlCentre;
    reg [31:0] nxtCarrier;
    always @* begin
        // Second half of a strong uplink pair reuses the first half's step
        stepSel = (pairSecond && isAul) ? step_ff : macStep;
        chanSel = ctrl_ff[`BFSK_F_HOPEN] ? hopTab_ff[hopIdx_ff] : chan_ff;
        dlCentre = dlBase_ff + {24'h000000, chanSel} * `BFSK_DL_SPC_HZ;
        case (link)
            `BFSK_LINK_ADL:
                nxtCarrier = dlCentre - (`BFSK_DL_SPC_HZ >> 1)
                    + (ctrl_ff[`BFSK_F_SLOT40] ? `BFSK_SLOT_A1
                    : `BFSK_SLOT_A0) * `BFSK_GRID_HZ;
            `BFSK_LINK_AUL:
                nxtCarrier = ulBase_ff
                    + {24'h000000, chan_ff} * `BFSK_UL_SPC_HZ
                    - (`BFSK_SPAN_HZ >> 1)
                    + {24'h000000, stepSel} * STEP_HZ;
            default:
                nxtCarrier = dlCentre - (`BFSK_DL_SPC_HZ >> 1)
                    + `BFSK_SLOT_X * `BFSK_GRID_HZ;
        endcase
    end

    // Burst sequencer: idle, guard, burst, ramp-down
    // Ramp-down is not counted in the next guard; bursts meet in idle
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
            tmr_ff <= 32'h00000000;
            bitCnt_ff <= 32'h00000000;
            bitsLeft_ff <= 16'h0000;
            step_ff <= 8'h00;
            carrier_ff <= 32'h00000000;
            txBit <= 1'b0;
            bitTake <= 1'b0;
            synthLoad <= 1'b0;
            paOn <= 1'b0;
            rampBusy <= 1'b0;
            guardActive <= 1'b0;
            burstDone <= 1'b0;
        end else begin
            bitTake <= 1'b0;
            synthLoad <= 1'b0;
            burstDone <= 1'b0;
            tmr_ff <= tmr_ff + 32'h1;
            bitCnt_ff <= lastBitCyc ? 32'h00000000 : bitCnt_ff + 32'h1;
            case (state_ff)
                S_IDLE: begin
                    bitCnt_ff <= 32'h00000000;
                    // Request ignored while disabled or mode reserved
                    if (burstReq && ctrl_ff[`BFSK_F_EN] && modeOk) begin
                        state_ff <= S_GUARD;
                        tmr_ff <= 32'h00000000;
                        step_ff <= stepSel;
                        carrier_ff <= nxtCarrier;
                        synthLoad <= 1'b1;
                        guardActive <= 1'b1;
                        txBit <= 1'b1;
                    end
                end
                S_GUARD: begin
                    // No toggle on the closing edge: it would leak a
                    // one-cycle stray bit at burst power
                    if (lastBitCyc && tmr_ff != GUARD_CYC - 1)
                        txBit <= ~txBit;
                    if (tmr_ff == GUARD_CYC - 1) begin
                        state_ff <= S_BURST;
                        tmr_ff <= 32'h00000000;
                        bitCnt_ff <= 32'h00000000;
                        bitsLeft_ff <= burstBits;
                        guardActive <= 1'b0;
                        paOn <= 1'b1;
                        rampBusy <= 1'b1;
                    end
                end
                S_BURST: begin
                    // A burst shorter than the ramp lets the down-ramp win
                    if (tmr_ff == RAMP_CYC - 1)
                        rampBusy <= 1'b0;
                    if (bitCnt_ff == 32'h00000000) begin
                        if (bitsLeft_ff == 16'h0000) begin
                            state_ff <= S_DOWN;
                            tmr_ff <= 32'h00000000;
                            paOn <= 1'b0;
                            rampBusy <= 1'b1;
                        end else begin
                            bitTake <= 1'b1;
                            txBit <= macBit;
                            bitsLeft_ff <= bitsLeft_ff - 16'h0001;
                        end
                    end
                end
                // Power is already low; the tone keeps running meanwhile
                S_DOWN: begin
                    if (tmr_ff == RAMP_CYC - 1) begin
                        state_ff <= S_IDLE;
                        rampBusy <= 1'b0;
                        burstDone <= 1'b1;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // Tone follows the bit one cycle later; carrier only moves in guard
    // The PA level, not the tone, marks silence between bursts
    always @(posedge clock or posedge rst) begin
        if (rst)
            toneFreq <= 32'h00000000;
        else if (txBit)
            toneFreq <= carrier_ff + `BFSK_DEV_HZ;
        else
            toneFreq <= carrier_ff - `BFSK_DEV_HZ;
    end
endmodule

// File: rtl/bfsk_regs.vh
// Register map, field positions, reset values and timing for bfsk_ctrl.
// Assumes a 10 MHz system clock; figures are kept in their own units.
`ifndef BFSK_REGS_VH
`define BFSK_REGS_VH
`define BFSK_CTRL 8'h00
`define BFSK_CHAN 8'h04
`define BFSK_DLBASE 8'h08
`define BFSK_ULBASE 8'h0C
`define BFSK_HOPOFS 8'h10
`define BFSK_HOPLEN 8'h14
`define BFSK_HOPWR 8'h18
`define BFSK_STATUS 8'h1C
`define BFSK_CTRL_RST 32'h00000000
`define BFSK_F_EN 0
`define BFSK_F_LINK_LO 1
`define BFSK_F_LINK_HI 2
`define BFSK_F_BASE 3
`define BFSK_F_SLOT40 4
`define BFSK_F_HOPEN 5
`define BFSK_F_EPPC 6
`define BFSK_F_MODE_LO 8
`define BFSK_F_MODE_HI 11
`define BFSK_LINK_ADL 2'h0
`define BFSK_LINK_AUL 2'h1
`define BFSK_LINK_XDL 2'h2
`define BFSK_LINK_XUL 2'h3
`define BFSK_DEV_HZ 32'h000000FA
`define BFSK_GRID_HZ 32'h000001F4
`define BFSK_DL_SPC_HZ 32'h000061A8
`define BFSK_UL_SPC_HZ 32'h00003A98
`define BFSK_SPAN_HZ 32'h000036B0
`define BFSK_SLOT_A0 32'h0000000A
`define BFSK_SLOT_A1 32'h00000028
`define BFSK_SLOT_X 32'h00000019
`define BFSK_CLK_HZ 10000000
`define BFSK_DL_BPS 500
`define BFSK_UL_BPS_X2 125
`define BFSK_GUARD_MS 16
`define BFSK_RAMP_US 500
`define BFSK_SLOT_MS 400
`define BFSK_BIT_DL_CYC (`BFSK_CLK_HZ / `BFSK_DL_BPS)
`define BFSK_BIT_UL_CYC (`BFSK_CLK_HZ * 2 / `BFSK_UL_BPS_X2)
`define BFSK_GUARD_CYC (`BFSK_CLK_HZ / 1000 * `BFSK_GUARD_MS)
`define BFSK_RAMP_CYC (`BFSK_CLK_HZ / 1000000 * `BFSK_RAMP_US)
`define BFSK_SLOT_CYC (`BFSK_CLK_HZ / 1000 * `BFSK_SLOT_MS)
`endif

// File: dv/bfsk_chk_asserts.sv
// Port-level assertions for the burst controller.
// Bound to bfsk_ctrl; sees only its ports and count parameters.
`timescale 1ns/1ns
module bfsk_chk #(
    parameter GUARD_CYC = 160,
    parameter RAMP_CYC = 5
) (
    input wire clock,
    input wire rst,
    input wire bitTake,
    input wire txBit,
    input wire [31:0] toneFreq,
    input wire synthLoad,
    input wire paOn,
    input wire rampBusy,
    input wire guardActive
);
    logic [31:0] guardCnt_ff;
    logic [31:0] rampCnt_ff;
    // Counters stand in for repetitions far too long to unroll
    always @(posedge clock or posedge rst)
        if (rst) guardCnt_ff <= 32'h00000000;
        else guardCnt_ff <= guardActive ? guardCnt_ff + 1 : 32'h00000000;
    always @(posedge clock or posedge rst)
        if (rst) rampCnt_ff <= 32'h00000000;
        else rampCnt_ff <= rampBusy ? rampCnt_ff + 1 : 32'h00000000;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_entry;
        synthLoad ##0 guardActive;
    endsequence
    property p_entry;
        s_entry |-> txBit && !paOn;
    endproperty
    a_entry: assert property (p_entry) else $error("bad guard entry");
    property p_guardpwr;
        guardActive |-> !paOn;
    endproperty
    a_guardpwr: assert property (p_guardpwr) else $error("power in guard");
    property p_guardlen;
        $fell(guardActive) |-> guardCnt_ff == GUARD_CYC;
    endproperty
    a_guardlen: assert property (p_guardlen) else $error("guard length");
    property p_alt;
        guardActive && $changed(txBit) |=> $stable(txBit) [*8];
    endproperty
    a_alt: assert property (p_alt) else $error("guard bit too short");
    property p_tone;
        (guardActive || paOn) && !synthLoad && $changed(txBit) |=>
            toneFreq - $past(toneFreq) ==
            ($past(txBit) ? 32'h000001F4 : 32'hFFFFFE0C);
    endproperty
    a_tone: assert property (p_tone) else $error("tone step wrong");
    property p_ramplen;
        $fell(rampBusy) |-> rampCnt_ff == RAMP_CYC;
    endproperty
    a_ramplen: assert property (p_ramplen) else $error("ramp length");
    property p_rampon;
        $changed(paOn) |-> rampBusy;
    endproperty
    a_rampon: assert property (p_rampon) else $error("no ramp");
    property p_take;
        bitTake |-> paOn && !guardActive;
    endproperty
    a_take: assert property (p_take) else $error("bit at low power");
endmodule
bind bfsk_ctrl bfsk_chk #(.GUARD_CYC(GUARD_CYC), .RAMP_CYC(RAMP_CYC)) i_chk (
    .clock(clock), .rst(rst), .bitTake(bitTake), .txBit(txBit),
    .toneFreq(toneFreq), .synthLoad(synthLoad), .paOn(paOn),
    .rampBusy(rampBusy), .guardActive(guardActive));

// File: dv/bfsk_mac_model.sv
// MAC-side partner: requests bursts, offers a step and data bits.
// Driven by the bench through go, stepWant and pat.
`timescale 1ns/1ns
module bfsk_mac_model (
    input wire clock,
    input wire rst,
    input wire go,
    input wire [7:0] stepWant,
    input wire [15:0] pat,
    input wire synthLoad,
    input wire bitTake,
    output logic burstReq,
    output logic [7:0] macStep,
    output logic macBit
);
    logic [3:0] idx_ff;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            burstReq <= 1'b0;
            macStep <= 8'h00;
            idx_ff <= 4'h0;
        end else begin
            // Step is set on the same edge as the request and held past the burst
            if (go) begin
                burstReq <= 1'b1;
                macStep <= stepWant;
                idx_ff <= 4'h0;
            end else if (synthLoad)
                burstReq <= 1'b0;
            if (bitTake)
                idx_ff <= idx_ff + 4'h1;
        end
    end
    assign macBit = pat[idx_ff];
endmodule

// File: dv/bfsk_ctrl_bench.sv
// Bench for bfsk_ctrl: APB master, MAC model, tone and bit model.
// Counts shortened by parameter; one 100 ns clock.
`timescale 1ns/1ns
`include "bfsk_regs.vh"
module bfsk_ctrl_bench;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic frameStart = 0, pairSecond = 0, err;
    logic [7:0] paddr = 8'h00, stepWant = 8'h00, rnd = 8'h1B, st;
    logic [15:0] burstBits = 16'h0004, pat = 16'h0000;
    logic [31:0] pwdata = 32'h00000000, car, q, lk;
    logic pready, pslverr, burstReq, macBit, bitTake, txBit, synthLoad;
    logic paOn, rampBusy, guardActive, burstDone, phaseCont;
    logic [7:0] macStep, hopOffset;
    logic [31:0] prdata, toneFreq;
    localparam logic [31:0] CHAN = 32'h00000002;
    int failures, checks, cyc;
    initial forever #50 clock = ~clock;
    bfsk_ctrl #(.BIT_DL_CYC(20), .BIT_UL_CYC(160), .GUARD_CYC(160),
        .RAMP_CYC(5), .SLOT_CYC(400)) i_bfsk_ctrl (.*);
    bfsk_mac_model i_bfsk_mac_model (.*);
    task chk(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // Only the bench timeout ends a wait for pready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] e,
               input logic ee);
        apb(0, a, 32'h00000000);
        chk(what, q, e);
        chk(what, err, ee);
    endtask
    task burst(input logic [31:0] c, input int per);
        int g, k;
        logic pb;
        g = 0;
        k = 0;
        @(posedge clock);
        go <= 1;
        @(posedge clock);
        go <= 0;
        while (synthLoad !== 1'b1)
            @(negedge clock);
        pb = txBit;
        chk("first guard bit", txBit, 1);
        do begin
            @(negedge clock);
            chk("tone", toneFreq, pb ? c + `BFSK_DEV_HZ : c - `BFSK_DEV_HZ);
            if (guardActive === 1'b1) begin
                g++;
                chk("guard bit", txBit, (g / per) % 2 == 0);
            end
            if (bitTake === 1'b1) begin
                chk("data bit", txBit, pat[k]);
                k++;
            end
            pb = txBit;
        end while (burstDone !== 1'b1);
        chk("bit count", k, burstBits);
        chk("phase", phaseCont, 1);
    endtask
    // Ceiling allows over five times the expected run
    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        rst <= 0;
        rdchk("ctrl reset", `BFSK_CTRL, `BFSK_CTRL_RST, 0);
        apb(1, `BFSK_CHAN, CHAN);
        apb(1, `BFSK_DLBASE, 32'h33000000);
        apb(1, `BFSK_ULBASE, 32'h32000000);
        apb(1, `BFSK_HOPOFS, 32'h0000005A);
        rdchk("chan", `BFSK_CHAN, CHAN, 0);
        rdchk("unmapped", 8'h20, 32'h00000000, 1);
        chk("hop offset", hopOffset, 32'h0000005A);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            if (i < 5) st = rnd % 8'h1D;
            stepWant <= rnd % 8'h1D;
            pat <= {8'h00, rnd};
            pairSecond <= (i == 5);
            lk = (i < 2) ? 32'h0 : (i < 4) ? i : 32'h1;
            apb(1, `BFSK_CTRL, 32'h9 | (lk << 1) | ((i == 1) << 4));
            car = 32'h33000000 + CHAN * `BFSK_DL_SPC_HZ
                - (`BFSK_DL_SPC_HZ >> 1) + `BFSK_GRID_HZ *
                (i == 0 ? `BFSK_SLOT_A0 : i == 1 ? `BFSK_SLOT_A1 : `BFSK_SLOT_X);
            if (lk == 1)
                car = 32'h32000000 + CHAN * `BFSK_UL_SPC_HZ
                    - (`BFSK_SPAN_HZ >> 1) + st * 32'h000001F4;
            burst(car, lk == 1 ? 160 : 20);
        end
        // Hop table: entry 10 at frame start, wrap to entry 0 a slot later
        apb(1, `BFSK_HOPLEN, 32'h0000000B);
        apb(1, `BFSK_HOPWR, 32'h00000A05);
        apb(1, `BFSK_HOPWR, 32'h00000007);
        apb(1, `BFSK_CTRL, 32'h00000029);
        @(posedge clock);
        frameStart <= 1;
        @(posedge clock);
        frameStart <= 0;
        rdchk("hop start", `BFSK_STATUS, 32'h0001000A, 0);
        car = 32'h33000000 + 5 * `BFSK_DL_SPC_HZ - (`BFSK_DL_SPC_HZ >> 1)
            + `BFSK_GRID_HZ * `BFSK_SLOT_A0;
        burst(car, 20);
        repeat (400) @(posedge clock);
        rdchk("hop wrap", `BFSK_STATUS, 32'h00010100, 0);
        burst(car + 2 * `BFSK_DL_SPC_HZ, 20);
        apb(1, `BFSK_CTRL, 32'h00000101);
        go <= 1;
        @(posedge clock);
        go <= 0;
        repeat (6) begin
            @(negedge clock);
            chk("reserved mode", guardActive, 0);
            chk("reserved load", synthLoad, 0);
        end
        chk("phase off", phaseCont, 0);
        tally_and_finish;
    end
endmodule
